// ===== soa_pkg.sv
package soa_pkg;
  // ****************************************
  // widths and timing
  // ****************************************
  localparam int SAMPLE_W = 16;
  localparam int COUNT_W = 15;
  localparam int ACC_W = 30;
  localparam int CHAN_W = 6;
  localparam int GAIN_W = 3;
  localparam logic [COUNT_W-1:0] OS_MIN = 15'h0002;
  localparam logic [COUNT_W-1:0] OS_MAX = 15'h4000;
  localparam int CLK_HZ = 10000000;
  localparam int MAINS_50_US = 20000;
  localparam int MAINS_60_NS = 16666000;
  // cycles per mains period at the core rate (longest time: round down)
  localparam int MAINS_50_CYC = MAINS_50_US * (CLK_HZ / 1000000);
  localparam int MAINS_60_CYC = MAINS_60_NS / (1000000000 / CLK_HZ);
  localparam int PER_W = 18;
  localparam logic [PER_W-1:0] PACE_RST = 18'h00000;

  typedef enum logic [2:0] {
    SOA_KIND_VOLT = 3'h0,
    SOA_KIND_TEMP = 3'h1,
    SOA_KIND_COLD = 3'h2,
    SOA_KIND_ZERO = 3'h3,
    SOA_KIND_DIG = 3'h4
  } soa_kind_t;

  typedef struct packed {
    soa_kind_t kind;
    logic [CHAN_W-1:0] chan;
    logic [GAIN_W-1:0] gain;
  } soa_entry_t;

  typedef struct packed {
    soa_entry_t entry;
    logic [SAMPLE_W-1:0] value;
  } soa_result_t;
endpackage

// ===== soa_pacer.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// conversion pacer for line-cycle mode
// ****************************************
// spreads one mains period evenly over the burst by fractional accumulation
module soa_pacer (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic enable,
  input wire logic restart,
  input wire logic [soa_pkg::PER_W-1:0] period,
  input wire logic [soa_pkg::COUNT_W-1:0] count,
  // tick
  output logic tick
);
  logic [soa_pkg::PER_W:0] acc_r;
  logic [soa_pkg::PER_W:0] acc_sum;
  wire step_over;

  assign acc_sum = acc_r + {4'h0, count};
  assign step_over = acc_sum >= {1'b0, period};
  assign tick = enable & step_over;

  always_ff @(posedge clk) begin
    if (rst || restart || !enable) begin
      acc_r <= {1'b0, soa_pkg::PACE_RST};
    end else if (step_over) begin
      acc_r <= acc_sum - {1'b0, period};
    end else begin
      acc_r <= acc_sum;
    end
  end
endmodule
`default_nettype wire

// ===== soa_averager.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - oversampling factor programmable from 2 to 16384 per entry
// - oversampling applies to voltage, temperature, cold-junction and autozero entries
// - digital entries give one reading regardless of oversampling
// - without oversampling, one conversion per entry in list order
// - burst of conversions per entry, channel and gain held steady
// - average all 16-bit results, deliver one value per entry
// - line-cycle mode averages a power-of-two count over one mains period
// - line-cycle mode stretches conversions to span 20 ms or 16.666 ms
module soa_averager (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // configuration
  input wire logic OS_ENABLE,
  input wire logic [soa_pkg::COUNT_W-1:0] OS_FACTOR,
  input wire logic LINE_ENABLE,
  input wire logic LINE_60HZ,
  // scan entry in
  input wire logic ENTRY_VALID,
  output logic ENTRY_READY,
  input wire soa_pkg::soa_entry_t ENTRY,
  // converter path
  output logic CONV_START,
  output soa_pkg::soa_entry_t CONV_SEL,
  input wire logic CONV_DONE,
  input wire logic [soa_pkg::SAMPLE_W-1:0] CONV_DATA,
  // digital input sample
  input wire logic [soa_pkg::SAMPLE_W-1:0] DIG_DATA,
  // result out
  output logic RESULT_VALID,
  input wire logic RESULT_READY,
  output soa_pkg::soa_result_t RESULT,
  // status
  output logic BUSY,
  output logic FACTOR_ERR
);
  typedef enum logic [2:0] {
    SOA_IDLE = 3'h0,
    SOA_START = 3'h1,
    SOA_WAIT = 3'h2,
    SOA_DIV = 3'h3,
    SOA_OUT = 3'h4
  } soa_state_t;
  localparam logic [4:0] DIV_TOP = 5'(soa_pkg::ACC_W - 1);

  soa_state_t state_r, state_nxt;
  soa_pkg::soa_entry_t sel_r;
  logic [soa_pkg::COUNT_W-1:0] target_r, done_r;
  logic [soa_pkg::ACC_W-1:0] acc_r;
  logic [soa_pkg::SAMPLE_W-1:0] avg_r;
  logic [soa_pkg::ACC_W-1:0] rem_r;
  logic [4:0] div_i_r;
  logic line_r, pace_ok_r;
  soa_pkg::soa_result_t result_r;

  // ****************************************
  // decode
  // ****************************************
  wire is_dig = (ENTRY.kind == soa_pkg::SOA_KIND_DIG);
  wire factor_ok = (OS_FACTOR >= soa_pkg::OS_MIN) && (OS_FACTOR <= soa_pkg::OS_MAX);
  wire pow2 = ((OS_FACTOR & (OS_FACTOR - 15'h0001)) == 15'h0000);
  // line mode only with a legal power-of-two count; otherwise plain oversampling
  wire line_ok = LINE_ENABLE && factor_ok && pow2;
  wire [soa_pkg::COUNT_W-1:0] want = (OS_ENABLE && factor_ok && !is_dig) ? OS_FACTOR
                                                                          : 15'h0001;
  wire take = (state_r == SOA_IDLE) && ENTRY_VALID;
  wire last = (done_r + 15'h0001) == target_r;
  wire [soa_pkg::PER_W-1:0] period = LINE_60HZ ? soa_pkg::PER_W'(soa_pkg::MAINS_60_CYC)
                                               : soa_pkg::PER_W'(soa_pkg::MAINS_50_CYC);
  wire pace_tick;
  wire conv_in = (state_r == SOA_WAIT) && CONV_DONE;
  wire div_start = conv_in && last;
  wire div_end = (state_r == SOA_DIV) && (div_i_r == 5'h00);

  // ****************************************
  // divide step
  // ****************************************
  // next dividend bit joins the partial remainder; a clear sign keeps the subtraction
  wire div_bit = acc_r[div_i_r];
  wire [soa_pkg::ACC_W:0] trial = {rem_r, div_bit} - {16'h0000, target_r};
  wire q_bit = !trial[soa_pkg::ACC_W];
  wire [soa_pkg::ACC_W-1:0] rem_shift = {rem_r[soa_pkg::ACC_W-2:0], div_bit};
  wire [soa_pkg::ACC_W-1:0] rem_step = q_bit ? trial[soa_pkg::ACC_W-1:0] : rem_shift;
  // the mean never exceeds one sample, so only zeros leave the top of the quotient
  wire [soa_pkg::SAMPLE_W-1:0] avg_nxt = {avg_r[soa_pkg::SAMPLE_W-2:0], q_bit};

  assign ENTRY_READY = (state_r == SOA_IDLE);
  assign CONV_START = (state_r == SOA_START) && (!line_r || pace_ok_r);
  assign CONV_SEL = sel_r;
  assign RESULT_VALID = (state_r == SOA_OUT);
  assign RESULT = result_r;
  assign BUSY = (state_r != SOA_IDLE);
  assign FACTOR_ERR = OS_ENABLE && !factor_ok;

  // stretch: next conversion is released only after the pacer's share of the period
  soa_pacer u_pacer (
    .clk(CORE_CLK),
    .rst(RST),
    .enable(line_r),
    .restart(take),
    .period(period),
    .count(target_r),
    .tick(pace_tick)
  );

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SOA_IDLE: begin
        if (ENTRY_VALID) begin
          state_nxt = is_dig ? SOA_OUT : SOA_START;
        end
      end
      SOA_START: begin
        if (CONV_START) begin
          state_nxt = SOA_WAIT;
        end
      end
      SOA_WAIT: begin
        if (CONV_DONE) begin
          state_nxt = last ? SOA_DIV : SOA_START;
        end
      end
      SOA_DIV: begin
        if (div_i_r == 5'h00) begin
          state_nxt = SOA_OUT;
        end
      end
      SOA_OUT: begin
        if (RESULT_READY) begin
          state_nxt = SOA_IDLE;
        end
      end
      default: state_nxt = SOA_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      state_r <= SOA_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // pace flag: set by tick, consumed by start; set wins
  // a conversion longer than two slots loses a tick and the burst overruns the period
  always_ff @(posedge CORE_CLK) begin
    if (RST || take) begin
      pace_ok_r <= 1'b0;
    end else if (pace_tick) begin
      pace_ok_r <= 1'b1;
    end else if (CONV_START) begin
      pace_ok_r <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      sel_r <= '0;
      target_r <= 15'h0001;
      line_r <= 1'b0;
    end else if (take) begin
      sel_r <= ENTRY;
      target_r <= want;
      line_r <= OS_ENABLE && line_ok && !is_dig;
    end
  end

  // ****************************************
  // accumulate and divide
  // ****************************************
  // 30 bits hold 16384 full-scale samples without wrapping
  always_ff @(posedge CORE_CLK) begin
    if (RST || take) begin
      acc_r <= '0;
      done_r <= '0;
    end else if (conv_in) begin
      acc_r <= acc_r + {14'h0000, CONV_DATA};
      done_r <= done_r + 15'h0001;
    end
  end

  // restoring divide, one quotient bit per cycle: avoids a wide combinational divider
  // costs 30 cycles per analog entry; digital entries never enter the divider
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      rem_r <= '0;
      avg_r <= '0;
      div_i_r <= 5'h00;
    end else if (div_start) begin
      rem_r <= '0;
      avg_r <= '0;
      div_i_r <= DIV_TOP;
    end else if (state_r == SOA_DIV) begin
      rem_r <= rem_step;
      avg_r <= avg_nxt;
      div_i_r <= div_end ? 5'h00 : div_i_r - 5'h01;
    end
  end

  // ****************************************
  // result register
  // ****************************************
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      result_r <= '0;
    end else if (take && is_dig) begin
      result_r <= {ENTRY, DIG_DATA};
    end else if (div_end) begin
      result_r <= {sel_r, avg_nxt};
    end
  end
endmodule
`default_nettype wire

// ===== soa_averager_props.sv
`timescale 1ns/1ps
`default_nettype none
// *****
// port checker
// *****
module soa_averager_props (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // configuration
  input wire logic OS_ENABLE,
  input wire logic [soa_pkg::COUNT_W-1:0] OS_FACTOR,
  input wire logic LINE_ENABLE,
  // entry, converter, result
  input wire logic ENTRY_VALID,
  input wire logic ENTRY_READY,
  input wire soa_pkg::soa_entry_t ENTRY,
  input wire logic CONV_START,
  input wire soa_pkg::soa_entry_t CONV_SEL,
  input wire logic [soa_pkg::SAMPLE_W-1:0] DIG_DATA,
  input wire logic RESULT_VALID,
  input wire logic RESULT_READY,
  input wire soa_pkg::soa_result_t RESULT,
  // status
  input wire logic BUSY,
  input wire logic FACTOR_ERR
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  wire logic take = ENTRY_VALID && ENTRY_READY;
  wire logic dig = ENTRY.kind == soa_pkg::SOA_KIND_DIG;
  idle_ready_a: assert property (ENTRY_READY == !BUSY)
    else $error("ready not idle");
  factor_flag_a: assert property (FACTOR_ERR == (OS_ENABLE &&
    (OS_FACTOR < soa_pkg::OS_MIN || OS_FACTOR > soa_pkg::OS_MAX))) else $error("factor flag");
  plain_start_a: assert property (take && !dig && !LINE_ENABLE |=> CONV_START)
    else $error("no start");
  dig_result_a: assert property (take && dig |=> RESULT_VALID && !CONV_START &&
    RESULT.value == $past(DIG_DATA)) else $error("digital result");
  sel_take_a: assert property (take |=> CONV_SEL == $past(ENTRY))
    else $error("sel not captured");
  sel_hold_a: assert property (BUSY && !take |=> $stable(CONV_SEL))
    else $error("sel moved");
  one_start_a: assert property (CONV_START |=> !CONV_START)
    else $error("double start");
  result_hold_a: assert property (RESULT_VALID && !RESULT_READY |=>
    RESULT_VALID && $stable(RESULT)) else $error("result dropped");
  line_wait_a: assert property (take && !dig && OS_ENABLE && LINE_ENABLE &&
    !FACTOR_ERR && ((OS_FACTOR & (OS_FACTOR - 15'h0001)) == 15'h0000) |=>
    (!CONV_START) [*8]) else $error("line start early");
endmodule
bind soa_averager soa_averager_props u_props (.CORE_CLK, .RST, .OS_ENABLE, .OS_FACTOR,
  .LINE_ENABLE, .ENTRY_VALID, .ENTRY_READY, .ENTRY, .CONV_START, .CONV_SEL, .DIG_DATA,
  .RESULT_VALID, .RESULT_READY, .RESULT, .BUSY, .FACTOR_ERR);
`default_nettype wire

// ===== soa_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
// *****
// converter: 1 to 4 cycles per conversion
// *****
module soa_conv_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // converter path
  input wire logic start,
  output logic done,
  output logic [15:0] data
);
  int cnt = 0;
  int seed = 32'h2786;
  always @(posedge clk) begin
    done <= 1'b0;
    // stale data toggles so a late sample never matches by luck
    data <= ~data;
    if (rst) begin
      cnt <= 0;
    end else if (start) begin
      cnt <= 1 + ($unsigned($random(seed)) % 4);
    end else if (cnt == 1) begin
      done <= 1'b1;
      data <= 16'($random(seed));
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

// ===== soa_averager_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
// *****
// averager bench
// *****
module soa_averager_tb;
  logic clk = 0, rst = 1, os = 0, line = 0, l60 = 0, e_vld = 0, r_rdy = 0;
  logic [14:0] fac = 0;
  logic [15:0] dig = 0, c_data;
  soa_pkg::soa_entry_t ent = '0, c_sel;
  soa_pkg::soa_result_t res;
  wire logic e_rdy, c_start, c_done, r_vld, busy, f_err;
  int error_cnt = 0, n_checks = 0, seed = 32'h2786, n_conv, j;
  logic [31:0] sum;
  int pick[5] = '{2, 3, 5, 64, 200};
  always #50 clk = ~clk;
  soa_averager u_soa_averager (.CORE_CLK(clk), .RST(rst), .OS_ENABLE(os), .OS_FACTOR(fac),
    .LINE_ENABLE(line), .LINE_60HZ(l60), .ENTRY_VALID(e_vld), .ENTRY_READY(e_rdy),
    .ENTRY(ent), .CONV_START(c_start), .CONV_SEL(c_sel), .CONV_DONE(c_done),
    .CONV_DATA(c_data), .DIG_DATA(dig), .RESULT_VALID(r_vld), .RESULT_READY(r_rdy),
    .RESULT(res), .BUSY(busy), .FACTOR_ERR(f_err));
  soa_conv_model u_soa_conv_model (.clk(clk), .rst(rst), .start(c_start), .done(c_done),
    .data(c_data));
  always @(posedge clk) if (c_done) begin
    sum <= sum + c_data;
    n_conv <= n_conv + 1;
  end
  function automatic int exp_n(logic [2:0] k, logic o, logic [14:0] f);
    return k == 3'h4 ? 0 : (o && f >= 2 && f <= 16384) ? int'(f) : 1;
  endfunction
  // conversions finished once the line-mode pacer has released this many slots
  function automatic int exp_paced(int cyc, int n);
    return cyc * n / soa_pkg::MAINS_60_CYC;
  endfunction
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic run_entry(input logic [2:0] k, input logic o, input logic [14:0] f);
    int i, n;
    @(negedge clk);
    ent = {k, 9'($random(seed))};
    os = o;
    fac = f;
    dig = 16'($random(seed));
    sum = 0;
    n_conv = 0;
    e_vld = 1;
    n = exp_n(k, o, f);
    @(negedge clk);
    e_vld = 0;
    `CHK("ferr", o && (f < 2 || f > 16384), f_err)
    for (i = 0; i < 90000 && r_vld !== 1'b1; i++) @(negedge clk);
    if (i == 90000) begin
      error_cnt++;
      stop_test();
    end
    repeat ($unsigned($random(seed)) % 3) @(negedge clk);
    `CHK("count", n, n_conv)
    `CHK("entry", ent, res.entry)
    `CHK("value", k == 3'h4 ? dig : 16'(sum / n), res.value)
    r_rdy = 1;
    @(negedge clk);
    r_rdy = 0;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst = 0;
    run_entry(3'h0, 0, 15'h0000);
    run_entry(3'h3, 1, 15'h0002);
    run_entry(3'h2, 1, 15'h4001);
    run_entry(3'h4, 1, 15'h0010);
    run_entry(3'h1, 1, 15'h4000);
    for (j = 0; j < 12; j++) begin
      run_entry(3'($unsigned($random(seed)) % 5), 1'($random(seed)), 15'(pick[j % 5]));
    end
    // line mode spans a whole mains period: too long to finish, so abort by reset
    @(negedge clk);
    line = 1;
    l60 = 1;
    os = 1;
    fac = 15'h1000;
    ent = '0;
    n_conv = 0;
    e_vld = 1;
    @(negedge clk);
    e_vld = 0;
    repeat (200) @(negedge clk);
    `CHK("paced", exp_paced(200, 4096), n_conv)
    `CHK("busy", 1'b1, busy)
    `CHK("early", 1'b0, r_vld)
    rst = 1;
    @(negedge clk);
    rst = 0;
    line = 0;
    `CHK("idle", 1'b0, busy)
    stop_test();
  end
endmodule
`default_nettype wire
